// >>> inc/zone_setpoint_arbiter_regs.vh
`ifndef ZONE_SETPOINT_ARBITER_REGS_VH
`define ZONE_SETPOINT_ARBITER_REGS_VH
// ==========================================================
// Register byte offsets
`define OFS_CTRL        7'h00
`define OFS_COMM_SP     7'h04
`define OFS_COMM_OCC    7'h08
`define OFS_BYP_MIN     7'h0c
`define OFS_CFG_FIRST   7'h10
`define OFS_CFG_LAST    7'h34
`define OFS_STATUS      7'h38
`define OFS_ACTIVE      7'h3c
`define OFS_EFF_FIRST   7'h40
`define OFS_EFF_LAST    7'h4c
// ==========================================================
// Field positions
`define CTRL_LOCAL_EN   0
`define CTRL_BI_PRESENT 1
`define COMM_SP_VALID   16
`define COMM_OCC_VALID  2
// ==========================================================
// Setpoint and limit table indices
`define CFG_UNOCC_COOL  0
`define CFG_STBY_COOL   1
`define CFG_OCC_COOL    2
`define CFG_OCC_HEAT    3
`define CFG_STBY_HEAT   4
`define CFG_UNOCC_HEAT  5
`define CFG_HEAT_HI     6
`define CFG_HEAT_LO     7
`define CFG_COOL_HI     8
`define CFG_COOL_LO     9
// ==========================================================
// Reset values, tenths of a degree Fahrenheit
`define RST_UNOCC_COOL  16'h0352
`define RST_STBY_COOL   16'h02f8
`define RST_OCC_COOL    16'h02e4
`define RST_OCC_HEAT    16'h02bc
`define RST_STBY_HEAT   16'h0294
`define RST_UNOCC_HEAT  16'h0258
`define RST_HEAT_HI     16'h0352
`define RST_HEAT_LO     16'h01f4
`define RST_COOL_HI     16'h0352
`define RST_COOL_LO     16'h01f4
`define KNOB_MIN        16'h01f4
`define KNOB_MAX        16'h0352
// ==========================================================
// Communicated occupancy codes
`define COCC_OCC        2'h0
`define COCC_UNOCC      2'h1
`define COCC_BYPASS     2'h2
`define COCC_STBY       2'h3
// ==========================================================
// Timing
`define CLK_PERIOD_NS   25
`define SECOND_NS       1000000000
`define CYC_PER_SEC     (`SECOND_NS / `CLK_PERIOD_NS)
`define SEC_PER_MIN     60
`define BYPASS_MIN_DEF  16'h0078
`endif

// >>> logic/bypass_timer.v
`timescale 1ns/1ps
`default_nettype none
`include "zone_setpoint_arbiter_regs.vh"

module bypass_timer #(
   parameter CYC_PER_SEC = `CYC_PER_SEC
) (
   input  wire        clk,
   input  wire        rst,
   input  wire        start,
   input  wire        cancel,
   input  wire [15:0] minutes,
   output reg         active
);

   // ==========================================================
   // Second and minute dividers
   reg  [31:0] pre_reg;
   reg  [5:0]  sec_reg;
   reg  [15:0] left_reg;
   wire        sec_tick = (pre_reg == CYC_PER_SEC - 1);
   wire        min_tick = sec_tick && (sec_reg == `SEC_PER_MIN - 1);

   always @(posedge clk) begin
      if (rst) begin
         pre_reg  <= 32'h0;
         sec_reg  <= 6'h0;
         left_reg <= 16'h0;
         active   <= 1'b0;
      end else if (cancel) begin
         active   <= 1'b0;
         left_reg <= 16'h0;
      end else if (start) begin
         // Restart the divider so the full duration is granted
         pre_reg  <= 32'h0;
         sec_reg  <= 6'h0;
         left_reg <= minutes;
         active   <= (minutes != 16'h0);
      end else if (active) begin
         pre_reg <= sec_tick ? 32'h0 : pre_reg + 32'h1;
         if (sec_tick)
            sec_reg <= (sec_reg == `SEC_PER_MIN - 1) ? 6'h0 : sec_reg + 6'h1;
         if (min_tick) begin
            left_reg <= left_reg - 16'h1;
            if (left_reg == 16'h1)
               active <= 1'b0;
         end
      end
   end

endmodule // bypass_timer
`default_nettype wire

// >>> logic/zone_setpoint_arbiter.v
// Contract
// - Knob setpoint accepted over 50..85 F, clamped to that range.
// - Offset is setpoint input minus mean of occupied cool and heat.
// - Offset shifts occupied and standby setpoints; unoccupied ones stay.
// - A communicated setpoint replaces the knob value.
// - Unoccupied mode always uses stored unoccupied setpoints.
// - Heating setpoints clamp to heat limits, cooling to cool limits.
// - Limits apply only to occupied and standby setpoints.
// - Knob used only if connected, enabled and no communicated setpoint.
// - Local enable never affects communicated setpoint handling.
// - Stored defaults used when no usable setpoint source exists.
// - On button in unoccupied starts timed bypass; Cancel ends it.
// - Occupancy comes from binary input or communicated request.
// - Occupied regulates to occupied heat or cool setpoint by mode.
// - Without input or request, the mode is occupied.
//
// Our own choices: the register offsets and the Avalon-MM slave port.
`timescale 1ns/1ps
`default_nettype none
`include "zone_setpoint_arbiter_regs.vh"

module zone_setpoint_arbiter #(
   parameter CYC_PER_SEC = `CYC_PER_SEC
) (
   input  wire        CLK,
   input  wire        RST,
   input  wire [6:0]  ADDRESS,
   input  wire        READ,
   input  wire        WRITE,
   input  wire [3:0]  BYTEENABLE,
   input  wire [31:0] WRITEDATA,
   output reg  [31:0] READDATA,
   output reg         WAITREQUEST,
   input  wire        KNOB_CONNECTED,
   input  wire [15:0] KNOB_VALUE,
   input  wire        OCC_INPUT,
   input  wire        ON_BUTTON,
   input  wire        CANCEL_BUTTON,
   input  wire        HEAT_MODE,
   output reg  [15:0] ACTIVE_SP,
   output reg  [3:0]  OCC_MODE,
   output reg  [1:0]  SP_SOURCE
);

   // ==========================================================
   // Occupancy states, one-hot
   localparam [3:0] ST_OCC   = 4'h1;
   localparam [3:0] ST_UNOCC = 4'h2;
   localparam [3:0] ST_STBY  = 4'h4;
   localparam [3:0] ST_BYP   = 4'h8;
   localparam [1:0] SRC_DEF  = 2'h0;
   localparam [1:0] SRC_KNOB = 2'h1;
   localparam [1:0] SRC_COMM = 2'h2;

   // ==========================================================
   // Helpers
   function [15:0] clamp;
      input signed [16:0] v;
      input signed [15:0] lo;
      input signed [15:0] hi;
      begin
         if (v < lo)
            clamp = lo;
         else if (v > hi)
            clamp = hi;
         else
            clamp = v[15:0];
      end
   endfunction

   function [31:0] merge;
      input [31:0] old;
      input [31:0] wd;
      input [3:0]  be;
      integer i;
      begin
         merge = old;
         for (i = 0; i < 4; i = i + 1)
            if (be[i])
               merge[i*8 +: 8] = wd[i*8 +: 8];
      end
   endfunction

   // ==========================================================
   // Pin synchronisers, two flops before any use
   reg  [20:0] sync1_reg;
   reg  [20:0] sync2_reg;
   reg         on_d_reg;
   reg         cancel_d_reg;

   always @(posedge CLK) begin
      if (RST) begin
         sync1_reg    <= 21'h0;
         sync2_reg    <= 21'h0;
         on_d_reg     <= 1'b0;
         cancel_d_reg <= 1'b0;
      end else begin
         sync1_reg    <= {HEAT_MODE, CANCEL_BUTTON, ON_BUTTON, OCC_INPUT,
                          KNOB_CONNECTED, KNOB_VALUE};
         sync2_reg    <= sync1_reg;
         on_d_reg     <= sync2_reg[18];
         cancel_d_reg <= sync2_reg[19];
      end
   end

   wire [15:0] knob_s     = sync2_reg[15:0];
   wire        knob_con_s = sync2_reg[16];
   wire        occ_in_s   = sync2_reg[17];
   wire        on_rise    = sync2_reg[18] & ~on_d_reg;
   wire        cancel_rise = sync2_reg[19] & ~cancel_d_reg;
   wire        heat_s     = sync2_reg[20];

   // ==========================================================
   // Software-visible configuration
   reg         local_en_reg;
   reg         bi_present_reg;
   reg  [15:0] comm_sp_reg;
   reg         comm_sp_valid_reg;
   reg  [1:0]  comm_occ_reg;
   reg         comm_occ_valid_reg;
   reg  [15:0] byp_min_reg;
   reg  [15:0] cfg [0:9];
   reg  [15:0] eff [0:3];

   wire [4:0]  widx   = ADDRESS[6:2];
   wire        req    = READ | WRITE;
   wire        is_cfg = (ADDRESS >= `OFS_CFG_FIRST) && (ADDRESS <= `OFS_CFG_LAST);
   wire        is_eff = (ADDRESS >= `OFS_EFF_FIRST) && (ADDRESS <= `OFS_EFF_LAST);
   wire [3:0]  cfg_i  = widx[3:0] - 4'h4;
   wire [1:0]  eff_i  = widx[1:0];
   wire        wr_go  = WRITE & ~WAITREQUEST;
   wire [31:0] ctrl_w = {30'h0, bi_present_reg, local_en_reg};
   wire [31:0] csp_w  = {15'h0, comm_sp_valid_reg, comm_sp_reg};
   wire [31:0] cocc_w = {29'h0, comm_occ_valid_reg, comm_occ_reg};
   wire [31:0] byp_w  = {16'h0, byp_min_reg};
   wire [31:0] cfg_w  = {16'h0, cfg[cfg_i]};
   wire [31:0] ctrl_m = merge(ctrl_w, WRITEDATA, BYTEENABLE);
   wire [31:0] csp_m  = merge(csp_w, WRITEDATA, BYTEENABLE);
   wire [31:0] cocc_m = merge(cocc_w, WRITEDATA, BYTEENABLE);
   wire [31:0] byp_m  = merge(byp_w, WRITEDATA, BYTEENABLE);
   wire [31:0] cfg_m  = merge(cfg_w, WRITEDATA, BYTEENABLE);

   always @(posedge CLK) begin
      if (RST) begin
         local_en_reg       <= 1'b0;
         bi_present_reg     <= 1'b0;
         comm_sp_reg        <= 16'h0;
         comm_sp_valid_reg  <= 1'b0;
         comm_occ_reg       <= 2'h0;
         comm_occ_valid_reg <= 1'b0;
         byp_min_reg        <= `BYPASS_MIN_DEF;
         cfg[`CFG_UNOCC_COOL] <= `RST_UNOCC_COOL;
         cfg[`CFG_STBY_COOL]  <= `RST_STBY_COOL;
         cfg[`CFG_OCC_COOL]   <= `RST_OCC_COOL;
         cfg[`CFG_OCC_HEAT]   <= `RST_OCC_HEAT;
         cfg[`CFG_STBY_HEAT]  <= `RST_STBY_HEAT;
         cfg[`CFG_UNOCC_HEAT] <= `RST_UNOCC_HEAT;
         cfg[`CFG_HEAT_HI]    <= `RST_HEAT_HI;
         cfg[`CFG_HEAT_LO]    <= `RST_HEAT_LO;
         cfg[`CFG_COOL_HI]    <= `RST_COOL_HI;
         cfg[`CFG_COOL_LO]    <= `RST_COOL_LO;
      end else if (wr_go) begin
         if (ADDRESS == `OFS_CTRL) begin
            local_en_reg   <= ctrl_m[`CTRL_LOCAL_EN];
            bi_present_reg <= ctrl_m[`CTRL_BI_PRESENT];
         end
         if (ADDRESS == `OFS_COMM_SP) begin
            comm_sp_reg       <= csp_m[15:0];
            comm_sp_valid_reg <= csp_m[`COMM_SP_VALID];
         end
         if (ADDRESS == `OFS_COMM_OCC) begin
            comm_occ_reg       <= cocc_m[1:0];
            comm_occ_valid_reg <= cocc_m[`COMM_OCC_VALID];
         end
         if (ADDRESS == `OFS_BYP_MIN)
            byp_min_reg <= byp_m[15:0];
         if (is_cfg)
            cfg[cfg_i] <= cfg_m[15:0];
      end
   end

   // ==========================================================
   // Occupancy arbitration
   reg  [3:0] base_mode;
   wire       byp_active;

   always @* begin
      base_mode = ST_OCC;
      if (comm_occ_valid_reg) begin
         case (comm_occ_reg)
            `COCC_UNOCC:  base_mode = ST_UNOCC;
            `COCC_BYPASS: base_mode = ST_BYP;
            `COCC_STBY:   base_mode = ST_STBY;
            // Local input only toggles occupied and standby here
            default:      base_mode = (bi_present_reg && !occ_in_s) ? ST_STBY : ST_OCC;
         endcase
      end else if (bi_present_reg) begin
         base_mode = occ_in_s ? ST_OCC : ST_UNOCC;
      end
   end

   bypass_timer #(
      .CYC_PER_SEC (CYC_PER_SEC)
   ) u_bypass (
      .clk     (CLK),
      .rst     (RST),
      .start   (on_rise && (base_mode == ST_UNOCC)),
      .cancel  (cancel_rise || (base_mode != ST_UNOCC)),
      .minutes (byp_min_reg),
      .active  (byp_active)
   );

   wire [3:0] mode = (byp_active && base_mode == ST_UNOCC) ? ST_BYP : base_mode;

   // ==========================================================
   // Setpoint source and signed offset
   // Knob reading is clamped, so a bad wheel cannot push offsets far out
   wire [15:0] knob_sp = clamp({knob_s[15], knob_s}, `KNOB_MIN, `KNOB_MAX);
   reg  [1:0]  src;
   reg  [15:0] sp_in;

   always @* begin
      src   = SRC_DEF;
      sp_in = 16'h0;
      if (comm_sp_valid_reg) begin
         src   = SRC_COMM;
         sp_in = comm_sp_reg;
      end else if (knob_con_s && local_en_reg) begin
         src   = SRC_KNOB;
         sp_in = knob_sp;
      end
   end

   wire signed [16:0] mean_sum = {cfg[`CFG_OCC_COOL][15], cfg[`CFG_OCC_COOL]}
                               + {cfg[`CFG_OCC_HEAT][15], cfg[`CFG_OCC_HEAT]};
   wire signed [16:0] mean = {mean_sum[16], mean_sum[16:1]};
   wire signed [16:0] offset = (src == SRC_DEF) ? 17'h0
                             : ({sp_in[15], sp_in} - mean);

   // ==========================================================
   // Effective setpoints, recomputed every cycle
   wire signed [16:0] sc = {cfg[`CFG_STBY_COOL][15], cfg[`CFG_STBY_COOL]} + offset;
   wire signed [16:0] oc = {cfg[`CFG_OCC_COOL][15], cfg[`CFG_OCC_COOL]} + offset;
   wire signed [16:0] oh = {cfg[`CFG_OCC_HEAT][15], cfg[`CFG_OCC_HEAT]} + offset;
   wire signed [16:0] sh = {cfg[`CFG_STBY_HEAT][15], cfg[`CFG_STBY_HEAT]} + offset;

   always @(posedge CLK) begin
      if (RST) begin
         eff[0] <= 16'h0;
         eff[1] <= 16'h0;
         eff[2] <= 16'h0;
         eff[3] <= 16'h0;
      end else begin
         eff[0] <= clamp(sc, cfg[`CFG_COOL_LO], cfg[`CFG_COOL_HI]);
         eff[1] <= clamp(oc, cfg[`CFG_COOL_LO], cfg[`CFG_COOL_HI]);
         eff[2] <= clamp(oh, cfg[`CFG_HEAT_LO], cfg[`CFG_HEAT_HI]);
         eff[3] <= clamp(sh, cfg[`CFG_HEAT_LO], cfg[`CFG_HEAT_HI]);
      end
   end

   // ==========================================================
   // Active setpoint and status outputs
   reg [15:0] active_next;

   always @* begin
      case (mode)
         // Stored values pass unshifted and unlimited
         ST_UNOCC: active_next = heat_s ? cfg[`CFG_UNOCC_HEAT]
                                        : cfg[`CFG_UNOCC_COOL];
         ST_STBY:  active_next = heat_s ? eff[3] : eff[0];
         ST_OCC,
         ST_BYP:   active_next = heat_s ? eff[2] : eff[1];
         default:  active_next = heat_s ? eff[2] : eff[1];
      endcase
   end

   always @(posedge CLK) begin
      if (RST) begin
         ACTIVE_SP <= 16'h0;
         OCC_MODE  <= ST_OCC;
         SP_SOURCE <= SRC_DEF;
      end else begin
         ACTIVE_SP <= active_next;
         OCC_MODE  <= mode;
         SP_SOURCE <= src;
      end
   end

   // ==========================================================
   // Avalon slave: one wait state, then the access completes
   reg [31:0] rd_next;

   always @* begin
      rd_next = 32'h0;
      if (is_cfg)
         rd_next = cfg_w;
      else if (is_eff)
         rd_next = {16'h0, eff[eff_i]};
      else begin
         case (ADDRESS)
            `OFS_CTRL:     rd_next = ctrl_w;
            `OFS_COMM_SP:  rd_next = csp_w;
            `OFS_COMM_OCC: rd_next = cocc_w;
            `OFS_BYP_MIN:  rd_next = byp_w;
            `OFS_STATUS:   rd_next = {25'h0, byp_active, SP_SOURCE, OCC_MODE};
            `OFS_ACTIVE:   rd_next = {16'h0, ACTIVE_SP};
            default:       rd_next = 32'h0;
         endcase
      end
   end

   always @(posedge CLK) begin
      if (RST) begin
         WAITREQUEST <= 1'b1;
         READDATA    <= 32'h0;
      end else if (req && WAITREQUEST) begin
         WAITREQUEST <= 1'b0;
         if (READ)
            READDATA <= rd_next;
      end else begin
         WAITREQUEST <= 1'b1;
      end
   end

endmodule // zone_setpoint_arbiter
`default_nettype wire

// >>> sim/zone_sensor_model.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// Far side: knob, buttons, occupancy input and heat/cool demand
module zone_sensor_model (
   input  wire logic        clk,
   output logic             knob_con,
   output logic [15:0]      knob_val,
   output logic             occ_in,
   output logic             on_b,
   output logic             can_b,
   output logic             heat
);
   initial begin
      knob_con = 1'b0;
      knob_val = 16'h0000;
      occ_in   = 1'b1;
      on_b     = 1'b0;
      can_b    = 1'b0;
      heat     = 1'b0;
   end
   // An unplugged knob leaves a floating line, so never repeat the old value
   task automatic plug(input logic c, input logic [15:0] v);
      @(posedge clk);
      knob_con <= c;
      knob_val <= c ? v : ~knob_val;
   endtask
   task automatic occ(input logic v);
      @(posedge clk);
      occ_in <= v;
   endtask
   task automatic demand(input logic v);
      @(posedge clk);
      heat <= v;
   endtask
   // Held four cycles so the two-flop synchroniser sees a clean edge
   task automatic press(input logic cancel);
      @(posedge clk);
      if (cancel) can_b <= 1'b1;
      else on_b <= 1'b1;
      repeat (4) @(posedge clk);
      can_b <= 1'b0;
      on_b  <= 1'b0;
   endtask
endmodule // zone_sensor_model
`default_nettype wire

// >>> sim/zone_setpoint_arbiter_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module zsa_checker #(
   parameter CYC_PER_SEC = 4
) (
   input  wire logic        CLK,
   input  wire logic        RST,
   input  wire logic        READ,
   input  wire logic        WRITE,
   input  wire logic [31:0] READDATA,
   input  wire logic        WAITREQUEST,
   input  wire logic        KNOB_CONNECTED,
   input  wire logic        HEAT_MODE,
   input  wire logic [15:0] ACTIVE_SP,
   input  wire logic [3:0]  OCC_MODE,
   input  wire logic [1:0]  SP_SOURCE
);
   default clocking @(posedge CLK); endclocking
   default disable iff (RST);
   // ==========================================================
   // Bus handshake
   sequence taken_s;
      (READ || WRITE) && WAITREQUEST;
   endsequence
   sequence pulse_s;
      !WAITREQUEST ##1 WAITREQUEST;
   endsequence
   bus_answer_a: assert property (taken_s |=> pulse_s)
      else $error("wait request did not pulse low for one cycle");
   idle_wait_a: assert property (!READ && !WRITE && WAITREQUEST |=> WAITREQUEST)
      else $error("wait request dropped without a request");
   read_hold_a: assert property (!(READ && WAITREQUEST) |=> $stable(READDATA))
      else $error("read data changed outside a read");
   // ==========================================================
   // Mode and source
   reset_state_a: assert property (disable iff (1'b0) RST |=>
      OCC_MODE == 4'h1 && SP_SOURCE == 2'h0 && WAITREQUEST)
      else $error("wrong state after reset");
   mode_onehot_a: assert property ($onehot(OCC_MODE))
      else $error("occupancy mode not one-hot");
   source_code_a: assert property (SP_SOURCE != 2'h3)
      else $error("undefined setpoint source");
   knob_unplug_a: assert property ($fell(KNOB_CONNECTED) && SP_SOURCE == 2'h1
      |-> ##[1:6] SP_SOURCE != 2'h1)
      else $error("knob still used after unplug");
   unocc_steady_a: assert property (
      (OCC_MODE == 4'h2 && !WRITE && $stable(HEAT_MODE))[*6] |-> $stable(ACTIVE_SP))
      else $error("unoccupied setpoint moved without cause");
endmodule // zsa_checker
bind zone_setpoint_arbiter zsa_checker #(.CYC_PER_SEC(CYC_PER_SEC)) chk (
   .CLK(CLK), .RST(RST), .READ(READ), .WRITE(WRITE), .READDATA(READDATA),
   .WAITREQUEST(WAITREQUEST), .KNOB_CONNECTED(KNOB_CONNECTED), .HEAT_MODE(HEAT_MODE),
   .ACTIVE_SP(ACTIVE_SP), .OCC_MODE(OCC_MODE), .SP_SOURCE(SP_SOURCE));
`default_nettype wire

// >>> sim/testbench.sv
`timescale 1ns/1ps
`default_nettype none
`include "zone_setpoint_arbiter_regs.vh"
module testbench;
   logic        clk, rst, rd, wr_s, waitreq, knob_con, occ_in, on_b, can_b, heat;
   logic [6:0]  addr;
   logic [3:0]  be, occ_mode;
   logic [31:0] wdata, rdata, q;
   logic [15:0] knob, act_sp;
   logic [1:0]  sp_src;
   int          failures, tests_run, i;
   logic [15:0] dflt [10] = '{`RST_UNOCC_COOL, `RST_STBY_COOL, `RST_OCC_COOL, `RST_OCC_HEAT,
      `RST_STBY_HEAT, `RST_UNOCC_HEAT, `RST_HEAT_HI, `RST_HEAT_LO, `RST_COOL_HI, `RST_COOL_LO};
   logic [15:0] eff [4] = '{16'h02f8, 16'h02e4, 16'h02bc, 16'h0294};
   logic [3:0]  occ_exp [4] = '{4'h1, 4'h2, 4'h8, 4'h4};
   zone_setpoint_arbiter #(.CYC_PER_SEC(4)) DUT (
      .CLK(clk), .RST(rst), .ADDRESS(addr), .READ(rd), .WRITE(wr_s), .BYTEENABLE(be),
      .WRITEDATA(wdata), .READDATA(rdata), .WAITREQUEST(waitreq),
      .KNOB_CONNECTED(knob_con), .KNOB_VALUE(knob), .OCC_INPUT(occ_in), .ON_BUTTON(on_b),
      .CANCEL_BUTTON(can_b), .HEAT_MODE(heat), .ACTIVE_SP(act_sp), .OCC_MODE(occ_mode),
      .SP_SOURCE(sp_src));
   zone_sensor_model sensor (.clk(clk), .knob_con(knob_con), .knob_val(knob),
      .occ_in(occ_in), .on_b(on_b), .can_b(can_b), .heat(heat));
   // ==========================================================
   // Tasks
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         failures++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   // Holds the request until wait request is sampled low at a rising edge
   task automatic bus(input logic r, input logic [6:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk);
      addr  <= a;
      rd    <= r;
      wr_s  <= !r;
      wdata <= d;
      do begin
         @(posedge clk);
         n++;
      end while (waitreq !== 1'b0 && n < 20);
      q = rdata;
      rd   <= 1'b0;
      wr_s <= 1'b0;
      // A stuck slave ends the run here rather than skewing later checks
      if (n >= 20) begin
         check(32'h1, 32'h0);
         results();
      end
   endtask
   task automatic rdc(input logic [6:0] a, input logic [31:0] exp);
      bus(1'b1, a, 32'h0);
      check(q, exp);
   endtask
   task automatic pins(input logic [15:0] sp, input logic [3:0] m, input logic [1:0] s);
      repeat (8) @(posedge clk);
      check(act_sp, sp);
      check(occ_mode, m);
      check(sp_src, s);
   endtask
   task automatic results;
      $display("failures=%0d tests_run=%0d", failures, tests_run);
      if (failures == 0 && tests_run > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   // ==========================================================
   // Clock, watchdog and tests
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   initial begin
      repeat (20000) @(posedge clk);
      failures++;
      $display("[FAIL] %0t watchdog expired", $time);
      results();
   end
   initial begin
      rst = 1'b1; rd = 1'b0; wr_s = 1'b0; addr = 7'h00; be = 4'hf; wdata = 32'h0;
      failures = 0; tests_run = 0;
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      pins(16'h02e4, 4'h1, 2'h0);
      for (i = 0; i < 10; i++) rdc(7'h10 + 7'(4 * i), dflt[i]);
      for (i = 0; i < 4; i++) rdc(7'h40 + 7'(4 * i), eff[i]);
      rdc(7'h7c, 32'h0);
      bus(1'b0, `OFS_STATUS, 32'hffff_ffff);
      rdc(`OFS_STATUS, 32'h1);
      sensor.plug(1'b1, 16'h02da);
      pins(16'h02e4, 4'h1, 2'h0);
      bus(1'b0, `OFS_CTRL, 32'h1);
      pins(16'h02ee, 4'h1, 2'h1);
      for (i = 0; i < 4; i++) rdc(7'h40 + 7'(4 * i), eff[i] + 16'h000a);
      sensor.demand(1'b1);
      pins(16'h02c6, 4'h1, 2'h1);
      sensor.plug(1'b1, 16'h0190);
      pins(16'h01f4, 4'h1, 2'h1);
      rdc(7'h40, 32'h021c);
      rdc(7'h4c, 32'h01f4);
      sensor.plug(1'b0, 16'h0000);
      pins(16'h02bc, 4'h1, 2'h0);
      bus(1'b0, `OFS_CTRL, 32'h0);
      bus(1'b0, `OFS_COMM_SP, 32'h0001_02e4);
      pins(16'h02d0, 4'h1, 2'h2);
      rdc(`OFS_COMM_SP, 32'h0001_02e4);
      sensor.plug(1'b1, 16'h0258);
      bus(1'b0, `OFS_CTRL, 32'h1);
      pins(16'h02d0, 4'h1, 2'h2);
      sensor.demand(1'b0);
      bus(1'b0, 7'h30, 32'h02f3);
      pins(16'h02f3, 4'h1, 2'h2);
      bus(1'b0, 7'h30, 32'h0352);
      bus(1'b0, `OFS_CTRL, 32'h3);
      for (i = 0; i < 4; i++) begin
         bus(1'b0, `OFS_COMM_OCC, 32'h4 | i);
         repeat (8) @(posedge clk);
         check(occ_mode, occ_exp[i]);
      end
      bus(1'b0, `OFS_COMM_OCC, 32'h4);
      sensor.occ(1'b0);
      pins(16'h030c, 4'h4, 2'h2);
      bus(1'b0, `OFS_COMM_OCC, 32'h0);
      pins(16'h0352, 4'h2, 2'h2);
      bus(1'b0, 7'h10, 32'h0384);
      pins(16'h0384, 4'h2, 2'h2);
      sensor.demand(1'b1);
      pins(16'h0258, 4'h2, 2'h2);
      sensor.demand(1'b0);
      be <= 4'h1;
      // Only the low byte is enabled, so the minute count becomes 1
      bus(1'b0, `OFS_BYP_MIN, 32'hffff_ff01);
      be <= 4'hf;
      rdc(`OFS_BYP_MIN, 32'h1);
      sensor.press(1'b0);
      pins(16'h02f8, 4'h8, 2'h2);
      rdc(`OFS_STATUS, 32'h68);
      rdc(`OFS_ACTIVE, 32'h2f8);
      repeat (198) @(posedge clk);
      check(occ_mode, 4'h8);
      repeat (40) @(posedge clk);
      check(occ_mode, 4'h2);
      sensor.press(1'b0);
      pins(16'h02f8, 4'h8, 2'h2);
      sensor.press(1'b1);
      pins(16'h0384, 4'h2, 2'h2);
      results();
   end
endmodule // testbench
`default_nettype wire
